/* hw/t1ck_pkg.sv */
// Purpose: Constants for the timer 1 clock source and prescaler
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   Only byte lane 0 carries register data
package t1ck_pkg;
    // Register byte addresses
    localparam logic [7:0] ADR_PLL_CSR       = 8'h00;
    localparam logic [7:0] ADR_TIMER_B_CTRL  = 8'h04;
    // pll_control_and_status fields
    localparam int         BIT_LOW_SPEED     = 7;
    localparam int         BIT_ASYNC_SEL     = 2;
    localparam int         BIT_PHASE_START   = 1;
    localparam int         BIT_LOCK_FLAG     = 0;
    // timer_b_control fields
    localparam int         BIT_RES_B7        = 7;
    localparam int         BIT_RESTART       = 6;
    localparam int         POS_DEAD_PRE      = 4;
    localparam int         POS_DIV_SEL       = 0;
    localparam int         DIV_SEL_W         = 4;
    // Widest divide is 2**14 = 16384
    localparam int         PRE_CNT_W         = 14;
    // Clock source fuse value that selects the PLL
    localparam logic [3:0] FUSE_PLL_MODE     = 4'h1;
    // Reset values
    localparam logic [7:0] RST_PLL_CSR       = 8'h00;
    localparam logic [7:0] RST_TIMER_B_CTRL  = 8'h00;
    localparam logic [3:0] DIV_STOPPED       = 4'h0;
endpackage

/* hw/t1ck_pre_if.sv */
// Purpose: Carries base tick, restart and divide select to the prescaler
// Assumes: Single clock domain
// Notes:   tick is registered inside the prescaler
`timescale 1ns/1ps
`default_nettype none
interface t1ck_pre_if;
    logic       base_tick;
    logic       restart;
    logic [3:0] div_sel;
    logic       tick;
    modport ctrl (output base_tick, output restart, output div_sel,
                  input tick);
    modport pre  (input base_tick, input restart, input div_sel,
                  output tick);
endinterface
`default_nettype wire

/* hw/t1ck_prescaler.sv */
// Purpose: Power-of-two prescaler with stop setting and restart
// Assumes: base_tick marks one period of the chosen time base
// Notes:   Counter free-runs; taps select divide of 2**(sel-1)
`timescale 1ns/1ps
`default_nettype none
module t1ck_prescaler
    import t1ck_pkg::*;
#(
    parameter int CNT_W = PRE_CNT_W
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    // Control
    t1ck_pre_if.pre   pre
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } t1ck_pre_t;

    t1ck_pre_t        st;
    t1ck_pre_t        next_st;
    logic [CNT_W-1:0] mask;

    always_comb begin
        next_st = st;
        mask    = '0;
        // sel 1 gives the undivided base, sel 15 divides by 16384
        if (pre.div_sel != DIV_STOPPED) begin
            mask = CNT_W'((CNT_W+1)'(1) << (pre.div_sel - 4'h1)) - 1'b1;
        end
        next_st.tick = 1'b0;
        if (pre.restart) begin
            next_st.cnt = '0;
        end else if (pre.base_tick) begin
            next_st.cnt = st.cnt + 1'b1;
            // All zeros stops the timer
            next_st.tick = (pre.div_sel != DIV_STOPPED) &&
                           ((st.cnt & mask) == mask);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pre.tick = st.tick;
endmodule
`default_nettype wire

/* hw/t1ck_sync.sv */
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is a slowly changing level
// Notes:   First stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module t1ck_sync (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    // Level
    input  wire logic async_i,
    output logic      sync_o
);
    typedef struct packed {
        logic meta;
        logic stable;
    } t1ck_sync_t;

    t1ck_sync_t st;
    t1ck_sync_t next_st;

    always_comb begin
        next_st.meta   = async_i;
        next_st.stable = st.meta;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.stable;
endmodule
`default_nettype wire

/* hw/t1ck_top.sv */
// Purpose: Timer 1 clock source select, PLL control and prescaler
// Assumes: fast_tick_i is a one-cycle pulse per fast peripheral clock
//          period, already retimed to mclk_i
// Notes:   Registers sit behind a classic Wishbone slave
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module t1ck_top
    import t1ck_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Clocking environment
    input  wire logic [3:0]  clock_source_fuse_i,
    input  wire logic        pll_is_sysclk_i,
    input  wire logic        pll_locked_i,
    input  wire logic        fast_tick_i,
    // PLL and timer controls
    output logic             pll_start_o,
    output logic             rc_osc_start_o,
    output logic             low_speed_o,
    output logic             async_mode_o,
    output logic             timer_tick_o
);
    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
        logic       low_speed;
        logic       async_sel;
        logic       phase_start;
        logic       res_b7;
        logic [1:0] dead_pre;
        logic [3:0] div_sel;
        logic       restart;
        logic       src_now;
        logic       half_tog;
        logic       base_tick;
        logic       pll_start;
        logic       rc_start;
    } t1ck_state_t;

    t1ck_state_t st;
    t1ck_state_t next_st;
    logic        lock_sync;
    logic        pll_enabled;
    logic        enable_rd;
    logic        access;
    logic        wr_lane0;
    logic [7:0]  wd;

    t1ck_pre_if pre_bus ();

    t1ck_sync u_lock_sync (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (pll_locked_i),
        .sync_o    (lock_sync)
    );

    t1ck_prescaler #(
        .CNT_W (PRE_CNT_W)
    ) u_prescaler (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .pre       (pre_bus.pre)
    );

    always_comb begin
        enable_rd   = st.phase_start | pll_is_sysclk_i;
        pll_enabled = enable_rd |
                      (clock_source_fuse_i == FUSE_PLL_MODE);
        access      = wb_cyc_i & wb_stb_i & ~st.ack;
        wr_lane0    = access & wb_we_i & wb_sel_i[0];
        wd          = wb_dat_i[7:0];
    end

    always_comb begin
        next_st         = st;
        next_st.ack     = access;
        next_st.restart = 1'b0;

        if (wr_lane0 && wb_adr_i == ADR_PLL_CSR) begin
            // Cannot be raised while the PLL feeds the core
            if (!wd[BIT_LOW_SPEED] || !pll_is_sysclk_i) begin
                next_st.low_speed = wd[BIT_LOW_SPEED];
            end
            // Async mode needs an enabled PLL
            if (!wd[BIT_ASYNC_SEL] || pll_enabled) begin
                next_st.async_sel = wd[BIT_ASYNC_SEL];
            end
            next_st.phase_start = wd[BIT_PHASE_START];
            // Lock flag bit of the write is dropped
        end

        if (wr_lane0 && wb_adr_i == ADR_TIMER_B_CTRL) begin
            next_st.res_b7   = wd[BIT_RES_B7];
            next_st.dead_pre = wd[POS_DEAD_PRE +: 2];
            next_st.div_sel  = wd[POS_DIV_SEL +: DIV_SEL_W];
            // Only a one acts; a zero leaves nothing behind
            next_st.restart  = wd[BIT_RESTART];
        end

        next_st.rdata = 8'h00;
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                ADR_PLL_CSR: begin
                    // Bits 6:3 stay zero
                    next_st.rdata[BIT_LOW_SPEED]   = st.low_speed;
                    next_st.rdata[BIT_ASYNC_SEL]   = st.async_sel;
                    next_st.rdata[BIT_PHASE_START] = enable_rd;
                    next_st.rdata[BIT_LOCK_FLAG]   = lock_sync;
                end
                ADR_TIMER_B_CTRL: begin
                    next_st.rdata[BIT_RES_B7]              = st.res_b7;
                    next_st.rdata[POS_DEAD_PRE +: 2]       = st.dead_pre;
                    next_st.rdata[POS_DIV_SEL +: DIV_SEL_W] = st.div_sel;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        // Source switch retimed; prescaler flushed on it
        next_st.src_now = st.async_sel;
        if (st.src_now != st.async_sel) begin
            next_st.restart = 1'b1;
        end

        // Low speed passes every other fast pulse
        if (fast_tick_i) begin
            next_st.half_tog = ~st.half_tog;
        end
        if (st.src_now) begin
            next_st.base_tick = fast_tick_i &
                                (~st.low_speed | st.half_tog);
        end else begin
            next_st.base_tick = 1'b1;
        end

        // PLL start also wakes its RC reference
        next_st.pll_start = pll_enabled;
        next_st.rc_start  = pll_enabled;
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st          <= '0;
            st.div_sel  <= DIV_STOPPED;
        end else begin
            st <= next_st;
        end
    end

    assign pre_bus.base_tick = st.base_tick;
    assign pre_bus.restart   = st.restart;
    assign pre_bus.div_sel   = st.div_sel;

    assign wb_dat_o       = {24'h000000, st.rdata};
    assign wb_ack_o       = st.ack;
    assign pll_start_o    = st.pll_start;
    assign rc_osc_start_o = st.rc_start;
    assign low_speed_o    = st.low_speed;
    assign async_mode_o   = st.src_now;
    assign timer_tick_o   = pre_bus.tick;
endmodule
`default_nettype wire

/* tb/t1ck_top_sva.sv */
// Purpose: Port checks for the timer 1 clock select block
// Assumes: One clock; a write is taken with cyc, stb high, ack low
// Notes:   Environment inputs held steady around register writes
`timescale 1ns/1ps
`default_nettype none
module t1ck_chk
    import t1ck_pkg::*;
(
    // Clock and reset
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Environment and controls
    input wire logic [3:0]  clock_source_fuse_i,
    input wire logic        pll_is_sysclk_i,
    input wire logic        pll_start_o,
    input wire logic        rc_osc_start_o,
    input wire logic        low_speed_o,
    input wire logic        async_mode_o
);
    logic wr0;
    logic rd0;
    logic rdb;
    assign wr0 = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                 && wb_adr_i == ADR_PLL_CSR;
    assign rd0 = wb_ack_o && !wb_we_i && wb_adr_i == ADR_PLL_CSR;
    assign rdb = wb_ack_o && !wb_we_i && wb_adr_i == ADR_TIMER_B_CTRL;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    a_async_set: assert property (wr0 && wb_dat_i[2:1] == 2'b11
        && pll_start_o && !async_mode_o |-> ##2 async_mode_o)
        else $error("async select not applied");
    a_async_block: assert property (wr0 && wb_dat_i[2:1] == 2'b10
        && !pll_start_o && !pll_is_sysclk_i && !async_mode_o
        && clock_source_fuse_i != FUSE_PLL_MODE |=> !async_mode_o[*2])
        else $error("async select taken without pll");
    a_lsm_block: assert property (wr0 && wb_dat_i[7] && !low_speed_o
        && pll_is_sysclk_i && $past(pll_is_sysclk_i) |=> !low_speed_o[*2])
        else $error("low speed set under pll clock");
    a_start_forced: assert property (pll_is_sysclk_i
        || clock_source_fuse_i == FUSE_PLL_MODE |=> pll_start_o)
        else $error("pll start not forced");
    a_rc_match: assert property (rc_osc_start_o == pll_start_o)
        else $error("rc start differs from pll start");
    a_resv_zero: assert property (rd0 |-> wb_dat_o[6:3] == 4'h0)
        else $error("reserved bits not zero");
    a_restart_rd: assert property (rdb |-> !wb_dat_o[BIT_RESTART])
        else $error("restart bit read as one");
    a_enable_rd: assert property (rd0 && pll_is_sysclk_i
        && $past(pll_is_sysclk_i, 2) |-> wb_dat_o[BIT_PHASE_START])
        else $error("enable bit not one under pll clock");
endmodule
`default_nettype wire

/* tb/t1ck_top_tb.sv */
// Purpose: Self-checking bench for the timer 1 clock select block
// Assumes: Fast clock modelled as a tick every fourth system cycle
// Notes:   Reset reads, then the sync-mode divide table, then hand-written cases
`timescale 1ns/1ps
`default_nettype none
module t1ck_top_tb;
    import t1ck_pkg::*;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [3:0]  clock_source_fuse_i = 4'h0;
    logic        pll_is_sysclk_i = 1'b0;
    logic        pll_locked_i = 1'b0;
    logic        fast_tick_i = 1'b0;
    logic        pll_start_o;
    logic        rc_osc_start_o;
    logic        low_speed_o;
    logic        async_mode_o;
    logic        timer_tick_o;
    logic [1:0]  ft_cnt = 2'h0;
    logic [31:0] q;
    int          errors = 0;
    int          n_checks = 0;
    int          per;
    // Divide select beside tick spacing in cycles; 0 means no tick
    logic [3:0]  tsel [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'hf, 4'h0};
    int          tper [6] = '{1, 2, 4, 16, 16384, 0};

    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        ft_cnt      <= ft_cnt + 2'h1;
        fast_tick_i <= (ft_cnt == 2'h3);
    end

    t1ck_top t1ck_top_inst (.mclk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .clock_source_fuse_i, .pll_is_sysclk_i, .pll_locked_i, .fast_tick_i,
        .pll_start_o, .rc_osc_start_o, .low_speed_o, .async_mode_o,
        .timer_tick_o);

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int i;
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        i = 0;
        do begin
            @(posedge mclk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i == 20) begin
            errors++;
            close_out();
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
        wb(1'b0, a, 8'h00);
        chk(nm, e, q);
    endtask

    // Spacing between two ticks; the first tick may be partial
    task automatic measure();
        int i;
        i = 0;
        per = 0;
        while (timer_tick_o !== 1'b1 && i < 17000) begin
            @(posedge mclk_i);
            i++;
        end
        if (i < 17000) begin
            @(posedge mclk_i);
            per = 1;
            while (timer_tick_o !== 1'b1 && per < 17000) begin
                @(posedge mclk_i);
                per++;
            end
        end
    endtask

    task automatic spacing(input logic [3:0] s, input int e, input string nm);
        wb(1'b1, ADR_TIMER_B_CTRL, {4'h0, s});
        repeat (4) @(posedge mclk_i);
        measure();
        chk(nm, e, per);
    endtask

    initial begin
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rdc(ADR_PLL_CSR, 32'h0, "csr reset");
        rdc(ADR_TIMER_B_CTRL, 32'h0, "tbc reset");
        rdc(8'h08, 32'h0, "unmapped");
        for (int k = 0; k < 6; k++) begin
            spacing(tsel[k], tper[k], "sync spacing");
        end
        wb(1'b1, ADR_TIMER_B_CTRL, 8'h45);
        rdc(ADR_TIMER_B_CTRL, 32'h05, "restart readback");
        measure();
        repeat (6) @(posedge mclk_i);
        // Without a restart the next tick is about 7 cycles away
        wb(1'b1, ADR_TIMER_B_CTRL, 8'h45);
        per = 0;
        while (timer_tick_o !== 1'b1 && per < 40) begin
            @(posedge mclk_i);
            per++;
        end
        chk("restart delay", 32'h1, per > 10);
        pll_locked_i <= 1'b1;
        wb(1'b1, ADR_PLL_CSR, 8'h04);
        rdc(ADR_PLL_CSR, 32'h01, "async refused");
        wb(1'b1, ADR_PLL_CSR, 8'h02);
        repeat (2000) @(posedge mclk_i);
        rdc(ADR_PLL_CSR, 32'h03, "pll enabled");
        chk("pll start", 32'h3, {pll_start_o, rc_osc_start_o});
        wb(1'b1, ADR_PLL_CSR, 8'h06);
        spacing(4'h3, 16, "async spacing");
        wb(1'b1, ADR_TIMER_B_CTRL, 8'h00);
        wb(1'b1, ADR_PLL_CSR, 8'h86);
        spacing(4'h3, 32, "low speed spacing");
        chk("modes", 32'h3, {low_speed_o, async_mode_o});
        wb(1'b1, ADR_TIMER_B_CTRL, 8'h00);
        wb(1'b1, ADR_PLL_CSR, 8'h06);
        pll_is_sysclk_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        wb(1'b1, ADR_PLL_CSR, 8'h84);
        rdc(ADR_PLL_CSR, 32'h07, "pll sysclk");
        pll_is_sysclk_i <= 1'b0;
        clock_source_fuse_i <= FUSE_PLL_MODE;
        wb(1'b1, ADR_PLL_CSR, 8'h00);
        wb(1'b1, ADR_PLL_CSR, 8'h04);
        rdc(ADR_PLL_CSR, 32'h05, "fuse enable");
        // Mid-run reset; lock flag needs the synchroniser to refill
        sys_rst_i <= 1'b1;
        repeat (16) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk("modes mid reset", 32'h0, {low_speed_o, async_mode_o});
        chk("start mid reset", 32'h3, {pll_start_o, rc_osc_start_o});
        rdc(ADR_PLL_CSR, 32'h01, "csr mid reset");
        rdc(ADR_TIMER_B_CTRL, 32'h0, "tbc mid reset");
        close_out();
    end
endmodule

bind t1ck_top t1ck_chk t1ck_chk_inst (.mclk_i, .sys_rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .clock_source_fuse_i, .pll_is_sysclk_i, .pll_start_o,
    .rc_osc_start_o, .low_speed_o, .async_mode_o);
`default_nettype wire
